/* rtl/trr_regs.svh */
`ifndef TRR_REGS_SVH
`define TRR_REGS_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define TRR_A_EN0      3'h0
`define TRR_A_EN1      3'h1
`define TRR_A_EN2      3'h2
`define TRR_A_EN3      3'h3
`define TRR_A_STS      3'h4
`define TRR_A_MSK      3'h5

// -----------------------------------------------------------------------------
// Assigned enable bits per register and reset values
// -----------------------------------------------------------------------------
`define TRR_EN0_MASK   8'h18
`define TRR_EN1_MASK   8'h77
`define TRR_EN2_MASK   8'h73
`define TRR_EN3_MASK   8'h61
`define TRR_EN_RST     8'h00
`define TRR_STS_RST    8'h00
`define TRR_MSK_RST    8'h00

// -----------------------------------------------------------------------------
// Status and mask fields
// -----------------------------------------------------------------------------
`define TRR_STS_END    0
`define TRR_STS_ROUTED 1
`define TRR_STS_MASK   8'h03

// -----------------------------------------------------------------------------
// Timing: cycles of delay from a changed enable to its use
// -----------------------------------------------------------------------------
`define TRR_EN_DELAY   2

`endif

/* rtl/trr_pkg.sv */
`default_nettype none
package trr_pkg;
   // One bit per source that may ask for a transfer, in source index order 15..0.
   typedef struct packed {
      logic conversion_done_event;
      logic serial_transmit_empty;
      logic serial_receive_full;
      logic byte_timer_match_b;
      logic byte_timer_match_a;
      logic ft3_compare_match_b_event;
      logic ft3_compare_match_a_event;
      logic ft3_input_capture_event;
      logic ft2_compare_match_b_event;
      logic ft2_compare_match_a_event;
      logic ft2_input_capture_event;
      logic ft1_compare_match_b_event;
      logic ft1_compare_match_a_event;
      logic ft1_input_capture_event;
      logic external_request_one;
      logic external_request_zero;
   } trr_src_t;

   // The four enable registers, eight bits each.
   typedef logic [3:0][7:0] trr_en_t;

   // Report from the transfer controller at the end of one transfer.
   typedef struct packed {
      logic       done;
      logic       count_zero;
      logic [3:0] src;
   } trr_done_t;
endpackage
`default_nettype wire

/* rtl/trr_top.sv */
//----------------------------------------------------------------------------
// Function
// - Enable one sends source to transfer controller.
// - Enable zero sends source to CPU.
// - Only sixteen fixed sources may request transfers.
// - Priority evaluation takes two clock periods.
// - New enable applies third state after write.
// - Only software ever clears an enable bit.
// - Count zero raises CPU interrupt, same source.
//----------------------------------------------------------------------------
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "trr_regs.svh"

module trr_top (
   // Clock and reset.
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   // Register port.
   input  wire logic [2:0]        reg_addr_in,
   input  wire logic [7:0]        reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [7:0]        reg_rdata_out,
   // Interrupt sources and transfer controller report.
   input  wire trr_pkg::trr_src_t  src_req_in,
   input  wire trr_pkg::trr_done_t xfer_done_in,
   input  wire logic              cpu_ack_in,
   input  wire logic [3:0]        cpu_ack_src_in,
   // Routed requests.
   output trr_pkg::trr_src_t      dtc_req_out,
   output trr_pkg::trr_src_t      cpu_req_out,
   output logic                   irq_out
);

   // -------------------------------------------------------------------------
   // Source map
   // -------------------------------------------------------------------------

   // Picks each source's enable out of the four registers.
   function automatic trr_pkg::trr_src_t src_of(input trr_pkg::trr_en_t en);
      trr_pkg::trr_src_t s;
      s = '0;
      s.external_request_zero     = en[0][4];
      s.external_request_one      = en[0][3];
      s.ft1_input_capture_event   = en[1][4];
      s.ft1_compare_match_a_event = en[1][5];
      s.ft1_compare_match_b_event = en[1][6];
      s.ft2_input_capture_event   = en[1][0];
      s.ft2_compare_match_a_event = en[1][1];
      s.ft2_compare_match_b_event = en[1][2];
      s.ft3_input_capture_event   = en[2][4];
      s.ft3_compare_match_a_event = en[2][5];
      s.ft3_compare_match_b_event = en[2][6];
      s.byte_timer_match_a        = en[2][0];
      s.byte_timer_match_b        = en[2][1];
      s.serial_receive_full       = en[3][5];
      s.serial_transmit_empty     = en[3][6];
      s.conversion_done_event     = en[3][0];
      return s;
   endfunction

   // Assigned bits of one enable register.
   function automatic logic [7:0] en_mask(input logic [1:0] idx);
      unique case (idx)
         2'h0: en_mask = `TRR_EN0_MASK;
         2'h1: en_mask = `TRR_EN1_MASK;
         2'h2: en_mask = `TRR_EN2_MASK;
         2'h3: en_mask = `TRR_EN3_MASK;
      endcase
   endfunction

   // -------------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------------

   trr_pkg::trr_en_t  en_q;
   trr_pkg::trr_en_t  en_eff_q;
   logic [7:0]        sts_q;
   logic [7:0]        msk_q;
   logic [7:0]        rdata_q;
   logic              en_wr;
   logic [7:0]        sts_set;

   assign en_wr = reg_wr_in && (reg_addr_in[2] == 1'b0);

   // Enable registers change only on a software write.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en_q <= {4{`TRR_EN_RST}};
      end else if (en_wr) begin
         en_q[reg_addr_in[1:0]] <= reg_wdata_in & en_mask(reg_addr_in[1:0]);
      end
   end

   // One stage keeps the old setting for a request already latched, so a new one routes from the third state.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         en_eff_q <= {4{`TRR_EN_RST}};
      end else begin
         en_eff_q <= en_q;
      end
   end

   // Mask register.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         msk_q <= `TRR_MSK_RST;
      end else if (reg_wr_in && reg_addr_in == `TRR_A_MSK) begin
         msk_q <= reg_wdata_in & `TRR_STS_MASK;
      end
   end

   // -------------------------------------------------------------------------
   // Routing pipeline
   // -------------------------------------------------------------------------

   logic [15:0]       src_s1_q;
   logic [15:0]       eff_src;
   logic [15:0]       en_src;
   logic [15:0]       dtc_d;
   logic [15:0]       dtc_q;
   logic [15:0]       cpu_q;
   logic [15:0]       end_pend_q;

   assign eff_src = src_of(en_eff_q);
   assign en_src  = src_of(en_q);
   assign dtc_d   = src_s1_q & eff_src;

   // First period latches requests, second makes the routing decision.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_s1_q <= 16'h0000;
         dtc_q    <= 16'h0000;
         cpu_q    <= 16'h0000;
      end else begin
         src_s1_q <= src_req_in;
         dtc_q    <= dtc_d;
         cpu_q    <= src_s1_q & ~eff_src;
      end
   end

   // End-of-count requests stay pending until the CPU takes them; a set wins.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         end_pend_q <= 16'h0000;
      end else begin
         for (int i = 0; i < 16; i++) begin
            if (xfer_done_in.done && xfer_done_in.count_zero && xfer_done_in.src == i[3:0]) begin
               end_pend_q[i] <= 1'b1;
            end else if (cpu_ack_in && cpu_ack_src_in == i[3:0]) begin
               end_pend_q[i] <= 1'b0;
            end
         end
      end
   end

   assign dtc_req_out = trr_pkg::trr_src_t'(dtc_q);
   assign cpu_req_out = trr_pkg::trr_src_t'(cpu_q | end_pend_q);

   // -------------------------------------------------------------------------
   // Status, interrupt and read port
   // -------------------------------------------------------------------------

   always_comb begin
      sts_set = 8'h00;
      sts_set[`TRR_STS_END]    = xfer_done_in.done && xfer_done_in.count_zero;
      sts_set[`TRR_STS_ROUTED] = |(dtc_d & ~dtc_q);
   end

   // Sticky status, cleared by writing one; a new event beats the clear.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sts_q <= `TRR_STS_RST;
      end else if (reg_wr_in && reg_addr_in == `TRR_A_STS) begin
         sts_q <= (sts_q & ~reg_wdata_in) | sts_set;
      end else begin
         sts_q <= sts_q | sts_set;
      end
   end

   assign irq_out = |(sts_q & msk_q);

   // Read data stand in the cycle after the read strobe only.
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            `TRR_A_EN0, `TRR_A_EN1, `TRR_A_EN2, `TRR_A_EN3: rdata_q <= en_q[reg_addr_in[1:0]];
            `TRR_A_STS: rdata_q <= sts_q;
            `TRR_A_MSK: rdata_q <= msk_q;
            default:    rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_out = rdata_q;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------

   dtc_route_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ##2 dtc_q == ($past(src_req_in, 2) & $past(eff_src)))
      else $error("Transfer request does not follow source and enable.");

   cpu_route_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ##2 cpu_q == ($past(src_req_in, 2) & ~$past(eff_src)))
      else $error("CPU request does not follow source and cleared enable.");

   no_overlap_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ##2 (dtc_q | cpu_q) == $past(src_req_in, 2) && (dtc_q & cpu_q) == 16'h0000)
      else $error("Request not routed to exactly one destination two periods later.");

   unassigned_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (en_q[0] & ~`TRR_EN0_MASK) == 8'h00 && (en_q[1] & ~`TRR_EN1_MASK) == 8'h00 &&
      (en_q[2] & ~`TRR_EN2_MASK) == 8'h00 && (en_q[3] & ~`TRR_EN3_MASK) == 8'h00)
      else $error("Unassigned enable bit set.");

   eff_delay_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ##2 dtc_q == ($past(src_req_in, 2) & $past(en_src, 2)))
      else $error("Enable setting applied at the wrong state.");

   keep_enable_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      !en_wr |=> en_q == $past(en_q))
      else $error("Enable changed without a software write.");

   end_irq_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (xfer_done_in.done && xfer_done_in.count_zero) |=> end_pend_q[$past(xfer_done_in.src)] && sts_q[0])
      else $error("Exhausted count did not raise a CPU request.");

   irq_level_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (|(sts_q & msk_q) && !(reg_wr_in && (reg_addr_in == `TRR_A_STS || reg_addr_in == `TRR_A_MSK))) |=> irq_out)
      else $error("Interrupt output dropped without a status clear or mask write.");

endmodule  // trr_top
`default_nettype wire

/* test/trr_far.sv */
`timescale 1ns/1ps
`default_nettype none

module trr_far (
   // Clock, reset and pace.
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              slow_in,
   // Routed requests seen.
   input  wire trr_pkg::trr_src_t dtc_req_in,
   input  wire trr_pkg::trr_src_t cpu_req_in,
   // Reports back to the router.
   output trr_pkg::trr_done_t     done_out,
   output logic                   ack_out,
   output logic [3:0]             ack_src_out
);
   logic [2:0] wait_q;
   logic [1:0] left_q;

   // Serves the lowest routed request, and every third transfer ends its count.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         done_out <= '0;
         ack_out <= 1'b0;
         ack_src_out <= 4'h0;
         wait_q <= 3'h0;
         left_q <= 2'h2;
      end else begin
         done_out <= '0;
         ack_out <= 1'b0;
         if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
         end else begin
            wait_q <= slow_in ? 3'h7 : 3'h1;
            if (|dtc_req_in) begin
               left_q <= (left_q == 2'h0) ? 2'h2 : left_q - 2'h1;
            end
            for (int i = 15; i >= 0; i--) begin
               if (cpu_req_in[i]) begin
                  ack_out <= 1'b1;
                  ack_src_out <= 4'(i);
               end
               if (dtc_req_in[i]) begin
                  done_out <= {1'b1, left_q == 2'h0, 4'(i)};
               end
            end
         end
      end
   end
endmodule // trr_far

`default_nettype wire

/* test/test_transfer_request_routing.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trr_regs.svh"

module test_transfer_request_routing;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic [2:0]         addr = 3'h0;
   logic [7:0]         wdata = 8'h00;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic               slow = 1'b0;
   logic [7:0]         rdata;
   logic               irq;
   logic               ack;
   logic [3:0]         ack_src;
   trr_pkg::trr_src_t  src = '0;
   trr_pkg::trr_src_t  transfer_controller;
   trr_pkg::trr_src_t  cpu;
   trr_pkg::trr_done_t done;
   int                 n_errors = 0;
   int                 checked = 0;
   localparam int      MAP[16] = '{4, 3, 12, 13, 14, 8, 9, 10, 20, 21, 22, 16, 17, 29, 30, 24};
   localparam logic [7:0] AMSK[4] = '{`TRR_EN0_MASK, `TRR_EN1_MASK, `TRR_EN2_MASK, `TRR_EN3_MASK};
   logic [7:0]         en_m[4];
   logic [7:0]         rd_m, sts_m, msk_m;
   logic [2:0]         ra;
   logic [7:0]         rw;
   logic [15:0]        st_d, st_c, o_d, o_c, pend;

   always #5 clk = ~clk;

   trr_top u_trr_top (.core_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .src_req_in(src), .xfer_done_in(done),
      .cpu_ack_in(ack), .cpu_ack_src_in(ack_src), .dtc_req_out(transfer_controller), .cpu_req_out(cpu), .irq_out(irq));
   trr_far u_trr_far (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .dtc_req_in(transfer_controller),
      .cpu_req_in(cpu), .done_out(done), .ack_out(ack), .ack_src_out(ack_src));

   // --------------------------------------------------------------------------
   // Reference model
   // --------------------------------------------------------------------------
   function automatic logic [15:0] env_f();
      for (int i = 0; i < 16; i++) env_f[i] = en_m[MAP[i] / 8][MAP[i] % 8];
   endfunction

   // Mirrors registers, the two-stage routing pipe and end-of-count requests.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en_m = '{default: 8'h00};
         {rd_m, sts_m, msk_m, st_d, st_c, o_d, o_c, pend} = '0;
      end else begin
         rd_m = !rd ? 8'h00 : (addr < 3'h4) ? en_m[addr[1:0]] : (addr == `TRR_A_STS) ? sts_m :
                (addr == `TRR_A_MSK) ? msk_m : 8'h00;
         if (wr && addr == `TRR_A_STS) sts_m = sts_m & ~wdata;
         if (|(st_d & ~o_d)) sts_m[`TRR_STS_ROUTED] = 1'b1;
         o_d = st_d;
         o_c = st_c;
         st_d = src & env_f();
         st_c = src & ~env_f();
         if (ack) pend[ack_src] = 1'b0;
         if (done.done && done.count_zero) begin
            pend[done.src] = 1'b1;
            sts_m[0] = 1'b1;
         end
         if (wr && addr < 3'h4) en_m[addr[1:0]] = wdata & AMSK[addr[1:0]];
         if (wr && addr == `TRR_A_MSK) msk_m = wdata & 8'h03;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Compares every result once settled, between clock edges.
   always @(negedge clk) begin
      if (rst_n) begin
         chk(transfer_controller, o_d);
         chk(cpu, o_c | pend);
         chk({8'h00, rdata}, {8'h00, rd_m});
         chk({15'h0000, irq}, {15'h0000, |(sts_m & msk_m)});
      end
   end

   // --------------------------------------------------------------------------
   // Stimulus
   // --------------------------------------------------------------------------
   task automatic op(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Cuts a hang short well past the expected run of about 2000 cycles.
   initial begin
      #60000;
      n_errors++;
      report_and_stop();
   end

   // Runs the tests in order.
   initial begin
      void'($urandom(32'hc10a1cac));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 8; a++) op(1'b0, 1'b1, 3'(a), 8'h00);
      $display("test 1 reset values done");
      for (int i = 0; i < 16; i++) begin
         src <= 16'(1) << i;
         op(1'b1, 1'b0, 3'(MAP[i] / 8), 8'(1 << (MAP[i] % 8)));
         repeat (3) @(posedge clk);
         op(1'b1, 1'b0, 3'(MAP[i] / 8), 8'h00);
         repeat (3) @(posedge clk);
      end
      $display("test 2 per source routing done");
      for (int a = 0; a < 4; a++) begin
         op(1'b1, 1'b0, 3'(a), 8'hff);
         op(1'b0, 1'b1, 3'(a), 8'h00);
      end
      op(1'b1, 1'b0, 3'h6, 8'hff);
      op(1'b0, 1'b1, 3'h6, 8'h00);
      $display("test 3 unassigned bits done");
      op(1'b1, 1'b0, `TRR_A_MSK, 8'h01);
      src <= 16'hffff;
      repeat (40) @(posedge clk);
      slow <= 1'b1;
      repeat (60) @(posedge clk);
      for (int a = 0; a < 5; a++) op(1'b0, 1'b1, 3'(a), 8'h00);
      src <= '0;
      repeat (4) @(posedge clk);
      op(1'b1, 1'b0, `TRR_A_STS, 8'hff);
      op(1'b0, 1'b1, `TRR_A_STS, 8'h00);
      $display("test 4 end of count done");
      for (int n = 0; n < 400; n++) begin
         src <= 16'($urandom);
         slow <= 1'($urandom);
         ra = 3'($urandom);
         rw = 8'($urandom);
         op(1'($urandom), 1'b0, ra, (ra < 3'h4) ? rw & AMSK[ra[1:0]] : rw);
         op(1'b0, 1'b1, 3'($urandom), 8'h00);
      end
      $display("test 5 random traffic done");
      report_and_stop();
   end
endmodule // test_transfer_request_routing

`default_nettype wire
